/* rtl/sdramf_defs.svh */
// constants for the sdram address map and pin front end
`ifndef SDRAMF_DEFS_SVH
`define SDRAMF_DEFS_SVH
`define SDRAMF_COL_MIN 8
`define SDRAMF_ROW_MIN 11
`define SDRAMF_BANKS 4
`define SDRAMF_ADDR_W 28
`define SDRAMF_PIN_ADDR_W 13
`define SDRAMF_DATA_W 32
`define SDRAMF_ROW_W 13
`define SDRAMF_COL_W 11
`define SDRAMF_MASK_W 4
`endif

/* rtl/sdramf_pkg.sv */
// types for the sdram address map and pin front end
package sdramf_pkg;
	typedef enum logic [1:0] {SDRAMF_CMD_NOP, SDRAMF_CMD_ACT, SDRAMF_CMD_READ, SDRAMF_CMD_WRITE} sdramf_cmd_t;
	typedef enum logic [1:0] {SDRAMF_ROWS_2K, SDRAMF_ROWS_4K, SDRAMF_ROWS_8K, SDRAMF_ROWS_RSV} sdramf_rows_t;
	typedef struct packed {
		logic [1:0] bank;
		logic [12:0] row;
		logic [10:0] column;
		logic [1:0] byteOffset;
	} sdramf_fields_t;
	typedef struct packed {
		logic memorySelectN;
		logic rowStrobeN;
		logic columnStrobeN;
		logic writeStrobeN;
	} sdramf_cmdpins_t;
endpackage

/* rtl/sdramf_front.sv */
// sdram address split, open row tracking and pin drive
`timescale 1ns/100ps
`include "sdramf_defs.svh"
module sdramf_front (
	input wire logic clk, // controller clock
	input wire logic reset_n, // async reset, active low
	input wire logic [`SDRAMF_ADDR_W-1:0] sysAddr, // system byte address
	input wire logic halfBus, // 1: 16-bit memory bus
	input wire logic [1:0] colSel, // column width minus 8
	input wire sdramf_pkg::sdramf_rows_t rowSel, // row count option
	input wire sdramf_pkg::sdramf_cmd_t cmdIn, // command from sequencer
	input wire logic [3:0] byteEnable, // bytes taking part, active high
	input wire logic [`SDRAMF_DATA_W-1:0] writeData, // write data
	input wire logic selfRefresh, // self refresh requested
	input wire logic [`SDRAMF_DATA_W-1:0] dataIn, // data pins input
	output logic memory_clock_out, // forwarded memory clock
	output logic memory_clock_enable, // clock enable, active high
	output logic memorySelectN, // chip select
	output logic rowStrobeN, // row strobe
	output logic columnStrobeN, // column strobe
	output logic write_strobe_n, // write strobe
	output logic [1:0] bankSelect, // bank lines
	output logic [`SDRAMF_PIN_ADDR_W-1:0] memAddr, // address pins
	output logic [`SDRAMF_MASK_W-1:0] byte_lane_mask_n, // byte masks
	output logic [`SDRAMF_DATA_W-1:0] dataOut, // data pins output
	output logic dataOe, // data pins driven
	output logic [`SDRAMF_DATA_W-1:0] readData, // sampled read data
	output logic rowHit // address hits the open row of its bank
);
	// ------------------------------
	// address split
	// ------------------------------
	sdramf_pkg::sdramf_fields_t fields;
	logic [4:0] colWidth;
	logic [4:0] rowWidth;
	logic [4:0] colBase;
	logic [5:0] rowBase;
	logic [5:0] bankBase;
	logic [`SDRAMF_ADDR_W-1:0] colMask;
	logic [`SDRAMF_ADDR_W-1:0] rowMask;
	always_comb begin
		colBase = halfBus ? 5'h01 : 5'h02;
		colWidth = 5'(`SDRAMF_COL_MIN) + {3'h0, colSel};
		unique case (rowSel)
			sdramf_pkg::SDRAMF_ROWS_2K: rowWidth = 5'(`SDRAMF_ROW_MIN);
			sdramf_pkg::SDRAMF_ROWS_4K: rowWidth = 5'(`SDRAMF_ROW_MIN + 1);
			default: rowWidth = 5'(`SDRAMF_ROW_MIN + 2);
		endcase
		rowBase = {1'b0, colBase} + {1'b0, colWidth};
		bankBase = rowBase + {1'b0, rowWidth};
		colMask = (`SDRAMF_ADDR_W'(1) << colWidth) - `SDRAMF_ADDR_W'(1);
		rowMask = (`SDRAMF_ADDR_W'(1) << rowWidth) - `SDRAMF_ADDR_W'(1);
		// linear byte space is cut into fields by shifts and masks
		fields.byteOffset = halfBus ? {1'b0, sysAddr[0]} : sysAddr[1:0];
		fields.column = 11'((sysAddr >> colBase) & colMask);
		fields.row = 13'((sysAddr >> rowBase) & rowMask);
		fields.bank = 2'(sysAddr >> bankBase);
	end

	// ------------------------------
	// open row table
	// ------------------------------
	logic rowOpen_q [`SDRAMF_BANKS];
	logic rowOpen_d [`SDRAMF_BANKS];
	logic [`SDRAMF_ROW_W-1:0] openRow_q [`SDRAMF_BANKS];
	logic [`SDRAMF_ROW_W-1:0] openRow_d [`SDRAMF_BANKS];
	genvar gb;
	generate
		for (gb = 0; gb < `SDRAMF_BANKS; gb++) begin : g_bank
			always_comb begin
				rowOpen_d[gb] = rowOpen_q[gb];
				openRow_d[gb] = openRow_q[gb];
				if (selfRefresh) begin
					rowOpen_d[gb] = 1'b0;
				end else if (cmdIn == sdramf_pkg::SDRAMF_CMD_ACT && fields.bank == 2'(gb)) begin
					rowOpen_d[gb] = 1'b1;
					openRow_d[gb] = fields.row;
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					rowOpen_q[gb] <= 1'b0;
					openRow_q[gb] <= 13'h0000;
				end else begin
					rowOpen_q[gb] <= rowOpen_d[gb];
					openRow_q[gb] <= openRow_d[gb];
				end
			end
		end
	endgenerate
	assign rowHit = rowOpen_q[fields.bank] && openRow_q[fields.bank] == fields.row;

	// ------------------------------
	// pin drive
	// ------------------------------
	sdramf_pkg::sdramf_cmdpins_t pins_d;
	sdramf_pkg::sdramf_cmdpins_t pins_q;
	logic [1:0] bank_d;
	logic [1:0] bank_q;
	logic [`SDRAMF_PIN_ADDR_W-1:0] addr_d;
	logic [`SDRAMF_PIN_ADDR_W-1:0] addr_q;
	logic [3:0] mask_d;
	logic [3:0] mask_q;
	logic [`SDRAMF_DATA_W-1:0] wdata_d;
	logic [`SDRAMF_DATA_W-1:0] wdata_q;
	logic oe_d;
	logic oe_q;
	logic cke_d;
	logic cke_q;
	logic [`SDRAMF_DATA_W-1:0] din1_q;
	logic [`SDRAMF_DATA_W-1:0] din2_q;
	always_comb begin
		pins_d = '{memorySelectN: 1'b1, rowStrobeN: 1'b1, columnStrobeN: 1'b1, writeStrobeN: 1'b1};
		bank_d = bank_q;
		addr_d = addr_q;
		mask_d = 4'hf;
		wdata_d = wdata_q;
		oe_d = 1'b0;
		cke_d = !selfRefresh;
		if (!selfRefresh) begin
			unique case (cmdIn)
				sdramf_pkg::SDRAMF_CMD_NOP: begin
					pins_d.memorySelectN = 1'b0;
				end
				sdramf_pkg::SDRAMF_CMD_ACT: begin
					pins_d.memorySelectN = 1'b0;
					pins_d.rowStrobeN = 1'b0;
					bank_d = fields.bank;
					addr_d = fields.row;
				end
				sdramf_pkg::SDRAMF_CMD_READ, sdramf_pkg::SDRAMF_CMD_WRITE: begin
					pins_d.memorySelectN = 1'b0;
					pins_d.columnStrobeN = 1'b0;
					pins_d.writeStrobeN = cmdIn != sdramf_pkg::SDRAMF_CMD_WRITE;
					bank_d = fields.bank;
					addr_d = {2'h0, fields.column};
					// 16-bit bus uses only the low two lanes
					mask_d = ~(halfBus ? {2'h0, byteEnable[1:0]} : byteEnable);
					if (cmdIn == sdramf_pkg::SDRAMF_CMD_WRITE) begin
						wdata_d = writeData;
						oe_d = 1'b1;
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_q <= '{memorySelectN: 1'b1, rowStrobeN: 1'b1, columnStrobeN: 1'b1, writeStrobeN: 1'b1};
			bank_q <= 2'h0;
			addr_q <= 13'h0000;
			mask_q <= 4'hf;
			wdata_q <= 32'h00000000;
			oe_q <= 1'b0;
			cke_q <= 1'b0;
			din1_q <= 32'h00000000;
			din2_q <= 32'h00000000;
		end else begin
			pins_q <= pins_d;
			bank_q <= bank_d;
			addr_q <= addr_d;
			mask_q <= mask_d;
			wdata_q <= wdata_d;
			oe_q <= oe_d;
			cke_q <= cke_d;
			din1_q <= dataIn;
			din2_q <= din1_q;
		end
	end
	assign memory_clock_out = clk;
	assign memory_clock_enable = cke_q;
	assign memorySelectN = pins_q.memorySelectN;
	assign rowStrobeN = pins_q.rowStrobeN;
	assign columnStrobeN = pins_q.columnStrobeN;
	assign write_strobe_n = pins_q.writeStrobeN;
	assign bankSelect = bank_q;
	assign memAddr = addr_q;
	assign byte_lane_mask_n = mask_q;
	assign dataOut = wdata_q;
	assign dataOe = oe_q;
	assign readData = din2_q;

	// ------------------------------
	// checks
	// ------------------------------
	sequence actIssued;
		cmdIn == sdramf_pkg::SDRAMF_CMD_ACT && !selfRefresh;
	endsequence
	sequence rowOnPins;
		!rowStrobeN && !memorySelectN && columnStrobeN && memAddr == $past(fields.row);
	endsequence
	chk_act_row_pins: assert property (@(posedge clk) disable iff (!reset_n) actIssued |=> rowOnPins)
		else $error("activate did not put row on pins");
	chk_col_pins: assert property (@(posedge clk) disable iff (!reset_n)
		(cmdIn == sdramf_pkg::SDRAMF_CMD_READ && !selfRefresh) |=> !columnStrobeN && write_strobe_n
		&& memAddr == {2'h0, $past(fields.column)})
		else $error("read did not put column on pins");
	chk_bank_lines: assert property (@(posedge clk) disable iff (!reset_n)
		actIssued |=> bankSelect == 2'($past(sysAddr) >> $past(bankBase)))
		else $error("bank lines wrong");
	chk_cke_self: assert property (@(posedge clk) disable iff (!reset_n)
		selfRefresh |=> !memory_clock_enable)
		else $error("clock enable high in self refresh");
	chk_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
		(cmdIn == sdramf_pkg::SDRAMF_CMD_WRITE && !selfRefresh && !halfBus) |=>
		byte_lane_mask_n == ~$past(byteEnable) && dataOe && !write_strobe_n)
		else $error("write masks or strobe wrong");
	chk_idle_mask: assert property (@(posedge clk) disable iff (!reset_n)
		(cmdIn == sdramf_pkg::SDRAMF_CMD_NOP) |=> byte_lane_mask_n == 4'hf && !dataOe)
		else $error("masks active when idle");
	chk_row_hit: assert property (@(posedge clk) disable iff (!reset_n)
		actIssued ##1 (!selfRefresh && cmdIn != sdramf_pkg::SDRAMF_CMD_ACT && $stable(sysAddr)) |-> rowHit)
		else $error("open row not recorded");
	chk_col_base32: assert property (@(posedge clk) disable iff (!reset_n)
		(!halfBus && colSel == 2'h0) |-> fields.column == {3'h0, sysAddr[9:2]}
		&& fields.byteOffset == sysAddr[1:0])
		else $error("32-bit column split wrong");
	chk_col_base16: assert property (@(posedge clk) disable iff (!reset_n)
		(halfBus && colSel == 2'h3 && rowSel == sdramf_pkg::SDRAMF_ROWS_8K) |->
		fields.column == sysAddr[11:1] && fields.row == sysAddr[24:12] && fields.bank == sysAddr[26:25])
		else $error("16-bit split wrong");
	chk_row_4k: assert property (@(posedge clk) disable iff (!reset_n)
		(!halfBus && colSel == 2'h1 && rowSel == sdramf_pkg::SDRAMF_ROWS_4K) |->
		fields.row == {1'b0, sysAddr[22:11]} && fields.bank == sysAddr[24:23])
		else $error("4K row split wrong");

	// ------------------------------
	// checks on data, pins, hold, refresh and address split
	// ------------------------------
	sequence writeIssued;
		cmdIn == sdramf_pkg::SDRAMF_CMD_WRITE && !selfRefresh;
	endsequence
	sequence writeOnPins;
		!memorySelectN && rowStrobeN && !columnStrobeN && !write_strobe_n && dataOe
		&& dataOut == $past(writeData) && memAddr == {2'h0, $past(fields.column)};
	endsequence
	chk_write_data: assert property (@(posedge clk) disable iff (!reset_n)
		writeIssued |=> writeOnPins)
		else $error("write did not drive data and column");
	chk_nop_pins: assert property (@(posedge clk) disable iff (!reset_n)
		(cmdIn == sdramf_pkg::SDRAMF_CMD_NOP && !selfRefresh) |=>
		!memorySelectN && rowStrobeN && columnStrobeN && write_strobe_n)
		else $error("nop did not select with strobes idle");
	chk_half_mask: assert property (@(posedge clk) disable iff (!reset_n)
		(halfBus && !selfRefresh
		&& (cmdIn == sdramf_pkg::SDRAMF_CMD_READ || cmdIn == sdramf_pkg::SDRAMF_CMD_WRITE))
		|=> byte_lane_mask_n[3:2] == 2'h3)
		else $error("upper lanes active on 16-bit bus");
	chk_act_mask: assert property (@(posedge clk) disable iff (!reset_n)
		actIssued |=> byte_lane_mask_n == 4'hf && !dataOe)
		else $error("masks active on activate");
	chk_read_oe: assert property (@(posedge clk) disable iff (!reset_n)
		(cmdIn == sdramf_pkg::SDRAMF_CMD_READ && !selfRefresh) |=> !dataOe)
		else $error("data pins driven on read");
	// read data takes two flops from the pins; the guard skips edges whose history lies in reset
	chk_read_delay: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reset_n, 2) |-> readData == $past(dataIn, 2))
		else $error("read data not two cycles behind pins");
	chk_cke_wake: assert property (@(posedge clk) disable iff (!reset_n)
		!selfRefresh |=> memory_clock_enable)
		else $error("clock enable low outside self refresh");
	chk_refresh_idle: assert property (@(posedge clk) disable iff (!reset_n)
		selfRefresh |=> memorySelectN && rowStrobeN && columnStrobeN && write_strobe_n
		&& byte_lane_mask_n == 4'hf && !dataOe)
		else $error("pins not idle in self refresh");
	chk_refresh_forget: assert property (@(posedge clk) disable iff (!reset_n)
		selfRefresh |=> !rowHit)
		else $error("open row kept through self refresh");
	// address and bank pins keep the last command's value while idle
	chk_addr_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(cmdIn == sdramf_pkg::SDRAMF_CMD_NOP || selfRefresh) |=> $stable(memAddr) && $stable(bankSelect))
		else $error("address pins moved while idle");
	chk_offset16: assert property (@(posedge clk) disable iff (!reset_n)
		halfBus |-> fields.byteOffset == {1'b0, sysAddr[0]})
		else $error("16-bit byte offset wrong");
	chk_col_base16lo: assert property (@(posedge clk) disable iff (!reset_n)
		(halfBus && colSel == 2'h0) |-> fields.column == {3'h0, sysAddr[8:1]})
		else $error("16-bit narrow column split wrong");
	chk_row_2k: assert property (@(posedge clk) disable iff (!reset_n)
		(!halfBus && colSel == 2'h2 && rowSel == sdramf_pkg::SDRAMF_ROWS_2K) |->
		fields.row == {2'h0, sysAddr[22:12]} && fields.bank == sysAddr[24:23])
		else $error("2K row split wrong");
	chk_row_2k_wide: assert property (@(posedge clk) disable iff (!reset_n)
		(!halfBus && colSel == 2'h3 && rowSel == sdramf_pkg::SDRAMF_ROWS_2K) |-> fields.column == sysAddr[12:2]
		&& fields.row == {2'h0, sysAddr[23:13]} && fields.bank == sysAddr[25:24])
		else $error("2K wide column split wrong");
	chk_row_8k32: assert property (@(posedge clk) disable iff (!reset_n)
		(!halfBus && colSel == 2'h0 && rowSel == sdramf_pkg::SDRAMF_ROWS_8K) |->
		fields.row == sysAddr[22:10] && fields.bank == sysAddr[24:23])
		else $error("8K row split wrong");
	chk_row_4k16: assert property (@(posedge clk) disable iff (!reset_n)
		(halfBus && colSel == 2'h2 && rowSel == sdramf_pkg::SDRAMF_ROWS_4K) |-> fields.column == {1'b0, sysAddr[10:1]}
		&& fields.row == {1'b0, sysAddr[22:11]} && fields.bank == sysAddr[24:23])
		else $error("16-bit 4K split wrong");
endmodule

/* testbench/sdramf_mem_model.sv */
// behavioural sdram device returning the last written word on a read
`timescale 1ns/100ps
module sdramf_mem_model (
	input wire logic clk, // memory clock
	input wire logic memorySelectN, // chip select
	input wire logic rowStrobeN, // row strobe
	input wire logic columnStrobeN, // column strobe
	input wire logic writeStrobeN, // write strobe
	input wire logic [31:0] dataOut, // controller data
	output logic [31:0] dataIn // data back to controller
);
	logic [31:0] store = 32'h0;
	logic [7:0] tick = 8'h0;
	logic drive = 1'b0;
	// active-low command decode
	always @(posedge clk) begin
		tick <= tick + 8'h1;
		drive <= !memorySelectN && rowStrobeN && !columnStrobeN && writeStrobeN;
		if (!memorySelectN && rowStrobeN && !columnStrobeN && !writeStrobeN) begin
			store <= dataOut;
		end
	end
	// released bus shows a pattern that changes every cycle
	assign dataIn = drive ? store : {4{tick ^ 8'ha5}};
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the sdram address split and pin drive
`timescale 1ns/100ps
module tb_top;
	typedef struct {logic [27:0] a; logic hb; logic [1:0] cs; logic [1:0] rs; logic [1:0] bk; logic [12:0] row;
		logic [10:0] col;} sdramf_vec_t;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [27:0] sysAddr = 28'h0;
	logic halfBus = 1'b0;
	logic [1:0] colSel = 2'h0;
	sdramf_pkg::sdramf_rows_t rowSel = sdramf_pkg::SDRAMF_ROWS_2K;
	sdramf_pkg::sdramf_cmd_t cmdIn = sdramf_pkg::SDRAMF_CMD_NOP;
	logic [3:0] byteEnable = 4'h0;
	logic [31:0] writeData = 32'h0;
	logic selfRefresh = 1'b0;
	logic [31:0] dataIn, dataOut, readData;
	logic memory_clock_out, memory_clock_enable, memorySelectN, rowStrobeN, columnStrobeN, write_strobe_n;
	logic dataOe, rowHit;
	logic [1:0] bankSelect;
	logic [12:0] memAddr;
	logic [3:0] byte_lane_mask_n;
	int error_cnt = 0;
	int cmp_count = 0;
	sdramf_vec_t vec[32];
	always #10 clk = ~clk;
	sdramf_front u_dut (.clk(clk), .reset_n(reset_n), .sysAddr(sysAddr), .halfBus(halfBus), .colSel(colSel),
		.rowSel(rowSel), .cmdIn(cmdIn), .byteEnable(byteEnable), .writeData(writeData), .selfRefresh(selfRefresh),
		.dataIn(dataIn), .memory_clock_out(memory_clock_out), .memory_clock_enable(memory_clock_enable),
		.memorySelectN(memorySelectN), .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN),
		.write_strobe_n(write_strobe_n), .bankSelect(bankSelect), .memAddr(memAddr),
		.byte_lane_mask_n(byte_lane_mask_n), .dataOut(dataOut), .dataOe(dataOe), .readData(readData), .rowHit(rowHit));
	sdramf_mem_model u_mem (.clk(memory_clock_out), .memorySelectN(memorySelectN), .rowStrobeN(rowStrobeN),
		.columnStrobeN(columnStrobeN), .writeStrobeN(write_strobe_n), .dataOut(dataOut), .dataIn(dataIn));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// command stands until the next call; pins checked at the falling edge after the taking edge
	task automatic cmd(input sdramf_pkg::sdramf_cmd_t c);
		cmdIn = c;
		@(negedge clk);
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		complete_run();
	end
	initial begin
		int off, cw, rw;
		for (int i = 0; i < 32; i++) begin
			vec[i].a = 28'h9e37b5c + 28'(i) * 28'h0123457;
			vec[i].hb = i[4];
			vec[i].cs = i[3:2];
			vec[i].rs = i[1:0];
			off = vec[i].hb ? 1 : 2;
			cw = 8 + int'(vec[i].cs);
			rw = (vec[i].rs == 2'h0) ? 11 : (vec[i].rs == 2'h1) ? 12 : 13;
			vec[i].col = 11'((vec[i].a >> off) & ((1 << cw) - 1));
			vec[i].row = 13'((vec[i].a >> (off + cw)) & ((1 << rw) - 1));
			vec[i].bk = 2'(vec[i].a >> (off + cw + rw));
		end
		repeat (16) @(negedge clk);
		chk(32'({memorySelectN, rowStrobeN, columnStrobeN, write_strobe_n, byte_lane_mask_n}), 32'hff);
		chk(32'({memory_clock_enable, dataOe, rowHit, memory_clock_out}), 32'h0);
		reset_n = 1'b1;
		$display("reset test done");
		for (int i = 0; i < 32; i++) begin
			sysAddr = vec[i].a;
			halfBus = vec[i].hb;
			colSel = vec[i].cs;
			rowSel = sdramf_pkg::sdramf_rows_t'(vec[i].rs);
			byteEnable = vec[i].hb ? {2'h0, i[1:0]} : i[3:0];
			cmd(sdramf_pkg::SDRAMF_CMD_ACT);
			chk(32'({memorySelectN, rowStrobeN, columnStrobeN, write_strobe_n}), 32'h3);
			chk(32'(memAddr), 32'(vec[i].row));
			chk(32'(bankSelect), 32'(vec[i].bk));
			chk(32'(rowHit), 32'h1);
			cmd(sdramf_pkg::SDRAMF_CMD_READ);
			chk(32'({memorySelectN, rowStrobeN, columnStrobeN, write_strobe_n, memAddr}), {15'h0, 4'h5, 2'h0, vec[i].col});
			chk(32'(byte_lane_mask_n), {28'h0, ~byteEnable});
		end
		$display("address map table test done");
		halfBus = 1'b0;
		byteEnable = 4'hf;
		writeData = 32'hc3a51e0f;
		// reopen the row under the 32-bit map before writing
		cmd(sdramf_pkg::SDRAMF_CMD_ACT);
		chk(32'(rowHit), 32'h1);
		cmd(sdramf_pkg::SDRAMF_CMD_WRITE);
		chk(32'({memorySelectN, rowStrobeN, columnStrobeN, write_strobe_n}), 32'h4);
		chk(dataOut, 32'hc3a51e0f);
		chk(32'({dataOe, byte_lane_mask_n}), 32'h10);
		cmd(sdramf_pkg::SDRAMF_CMD_READ);
		cmd(sdramf_pkg::SDRAMF_CMD_NOP);
		chk(32'({memorySelectN, rowStrobeN, columnStrobeN, write_strobe_n, byte_lane_mask_n}), 32'h7f);
		// one cycle in the memory plus two pin flops
		repeat (2) @(negedge clk);
		chk(readData, 32'hc3a51e0f);
		$display("write then read test done");
		chk(32'(rowHit), 32'h1);
		selfRefresh = 1'b1;
		@(negedge clk);
		cmd(sdramf_pkg::SDRAMF_CMD_ACT);
		chk(32'({memory_clock_enable, memorySelectN, rowStrobeN}), 32'h3);
		chk(32'(rowHit), 32'h0);
		selfRefresh = 1'b0;
		cmd(sdramf_pkg::SDRAMF_CMD_NOP);
		chk(32'({memory_clock_enable, memorySelectN}), 32'h2);
		$display("self refresh test done");
		complete_run();
	end
endmodule
